// >>> hw/scs_clock_select.sv
// System clock source selection, dividers, switching and fail-safe monitor
`timescale 1ns/10ps
`default_nettype none
module scs_clock_select (
   // Clock and reset
   input  wire logic                  ref_clk_in,
   input  wire logic                  rst_in,
   // Register port
   input  wire scs_pkg::scs_req_t     reg_req_in,
   output logic      [15:0]           reg_rdata_out,
   // Configuration words
   input  wire logic [2:0]            initial_source_select_in,
   input  wire logic [1:0]            primary_mode_select_in,
   input  wire logic                  fail_safe_enable_in,
   // Oscillator and loop sense
   input  wire logic                  fast_rc_clk_in,
   input  wire logic                  primary_osc_in_pin_in,
   input  wire logic                  secondary_osc_in_pin_in,
   input  wire logic                  slow_rc_clk_in,
   input  wire logic                  loop_clk_in,
   input  wire logic                  loop_locked_in,
   // Oscillator and loop control
   output logic                       primary_amp_enable_out,
   output logic                       primary_high_gain_out,
   output logic                       secondary_osc_enable_out,
   output logic                       slow_rc_enable_out,
   output logic      [5:0]            fast_rc_tune_out,
   output logic                       loop_enable_out,
   output logic                       loop_from_primary_out,
   output scs_pkg::scs_loop_t         loop_cfg_out,
   // Clock results and status
   output logic      [2:0]            current_source_out,
   output logic      [3:0]            clock_mode_out,
   output logic                       sys_clk_tick_out,
   output logic                       instr_clk_out,
   output logic                       peripheral_clock_out,
   output logic                       clock_fail_out
);
   import scs_pkg::*;

   logic [5:0]  async_vec;
   logic [5:0]  sync1_ff, sync2_ff, prev_ff;
   logic [5:0]  edge_vec;
   logic [5:0]  cfg1_ff, cfg2_ff;
   scs_src_t    cur_src_ff, new_src_ff;
   scs_pmode_t  pmode_ff;
   logic        fs_en_ff, lock_en_ff, fail_ff, sec_en_ff, sw_en_ff;
   logic [2:0]  doze_ff, frc_ps_ff;
   logic        doze_en_ff;
   logic [4:0]  pre_ff;
   logic [1:0]  post_ff;
   logic [8:0]  fb_ff;
   logic [5:0]  tune_ff;
   logic [7:0]  frc_cnt_ff, frc_mask;
   logic [6:0]  doze_cnt_ff, doze_mask;
   logic [2:0]  fs_cnt_ff, settle_ff;
   scs_sw_t     sw_ff;
   logic        frc_dn_edge, frc_d16_edge, sys_edge, new_edge, loop_lock;
   logic        fail_event, sw_done, wr_osc, wr_div, pll_pair;
   logic [15:0] osc_word;
   logic        sys_tick_ff, periph_ff, instr_ff, fail_out_ff;
   logic        amp_en_ff, gain_ff, sec_out_ff, slow_en_ff, loop_en_ff, loop_pri_ff;
   logic [15:0] rdata_ff;
   logic [3:0]  mode_ff;

   // Two flops on every pin or foreign-clock input before any use
   assign async_vec = {loop_locked_in, loop_clk_in, slow_rc_clk_in,
                       secondary_osc_in_pin_in, primary_osc_in_pin_in, fast_rc_clk_in};
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         sync1_ff <= 6'h00;
         sync2_ff <= 6'h00;
         prev_ff  <= 6'h00;
      end else begin
         sync1_ff <= async_vec;
         sync2_ff <= sync1_ff;
         prev_ff  <= sync2_ff;
      end
   end
   // Rising edges of each sensed clock; sampling limits usable rates to below half the reference
   assign edge_vec  = sync2_ff & ~prev_ff;
   assign loop_lock = sync2_ff[TK_LOCK];

   // Configuration words are synchronised too, then caught while reset is held
   always_ff @(posedge ref_clk_in) begin
      cfg1_ff <= {fail_safe_enable_in, primary_mode_select_in, initial_source_select_in};
      cfg2_ff <= cfg1_ff;
   end

   // Fast RC postscale counter, free running on fast RC edges
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         frc_cnt_ff <= 8'h00;
      end else if (edge_vec[TK_FRC]) begin
         frc_cnt_ff <= frc_cnt_ff + 8'h01;
      end
   end
   // Ratio is 2 to the power (select+1), 1:2 up to 1:256
   assign frc_mask     = 8'((9'h002 << frc_ps_ff) - 9'h001);
   assign frc_dn_edge  = edge_vec[TK_FRC] && ((frc_cnt_ff & frc_mask) == frc_mask);
   assign frc_d16_edge = edge_vec[TK_FRC] && (frc_cnt_ff[3:0] == 4'hf);

   // Edge pulse of the clock that a given source code selects
   function automatic logic src_edge(input scs_src_t s);
      unique case (s)
         SRC_FRC:     src_edge = edge_vec[TK_FRC];
         SRC_FRC_PLL: src_edge = edge_vec[TK_PLL];
         SRC_PRI:     src_edge = edge_vec[TK_PRI];
         SRC_PRI_PLL: src_edge = edge_vec[TK_PLL];
         SRC_SEC:     src_edge = edge_vec[TK_SEC];
         SRC_INTERNAL_SLOW_RC:    src_edge = edge_vec[TK_INTERNAL_SLOW_RC];
         SRC_FRC_D16: src_edge = frc_d16_edge;
         SRC_FRC_DN:  src_edge = frc_dn_edge;
      endcase
   endfunction

   function automatic logic is_loop(input scs_src_t s);
      is_loop = (s == SRC_FRC_PLL) || (s == SRC_PRI_PLL);
   endfunction

   function automatic logic uses_pri(input scs_src_t s);
      uses_pri = (s == SRC_PRI) || (s == SRC_PRI_PLL);
   endfunction

   assign sys_edge = src_edge(cur_src_ff);
   assign new_edge = src_edge(new_src_ff) && (!is_loop(new_src_ff) || loop_lock);
   assign wr_osc   = reg_req_in.wr && (reg_req_in.addr == ADDR_OSC_CTRL);
   assign wr_div   = reg_req_in.wr && (reg_req_in.addr == ADDR_CLK_DIV);
   // Loop to loop moves are refused; software must pass through plain fast RC
   assign pll_pair = is_loop(cur_src_ff) && is_loop(new_src_ff);

   // Fail-safe monitor counts slow RC edges with no system edge between them
   always_ff @(posedge ref_clk_in) begin
      if (rst_in || sys_edge) begin
         fs_cnt_ff <= 3'h0;
      end else if (edge_vec[TK_INTERNAL_SLOW_RC] && fs_cnt_ff != FAIL_LIMIT) begin
         fs_cnt_ff <= fs_cnt_ff + 3'h1;
      end
   end
   // Slow RC as system clock cannot check itself, so the monitor stays quiet then
   assign fail_event = fs_en_ff && !sys_edge && edge_vec[TK_INTERNAL_SLOW_RC] && cur_src_ff != SRC_INTERNAL_SLOW_RC
                       && (fs_cnt_ff == FAIL_LIMIT - 3'h1);

   // Run-time switch sequencer
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         sw_ff     <= SW_IDLE;
         settle_ff <= 3'h0;
         sw_done   <= 1'b0;
      end else begin
         sw_done <= 1'b0;
         if (fail_event) begin
            sw_ff   <= SW_IDLE;
            sw_done <= sw_en_ff;
         end else begin
            unique case (sw_ff)
               SW_IDLE: begin
                  settle_ff <= 3'h0;
                  if (sw_en_ff && !sw_done) begin
                     if (pll_pair || new_src_ff == cur_src_ff) begin
                        sw_done <= 1'b1;
                     end else begin
                        sw_ff <= SW_WAIT_NEW;
                     end
                  end
               end
               SW_WAIT_NEW: begin
                  if (settle_ff == SWITCH_SETTLE) begin
                     sw_ff <= SW_SWAP;
                  end else if (new_edge) begin
                     settle_ff <= settle_ff + 3'h1;
                  end
               end
               SW_SWAP: begin
                  // Hand over only in a cycle where neither clock has an edge
                  if (!sys_edge && !src_edge(new_src_ff)) begin
                     sw_ff   <= SW_IDLE;
                     sw_done <= 1'b1;
                  end
               end
               default: begin
                  sw_ff <= SW_IDLE;
               end
            endcase
         end
      end
   end

   // Current source: strap at power-on, then switches and fail-safe fallback
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         cur_src_ff <= scs_src_t'(cfg2_ff[2:0]);
         pmode_ff   <= scs_pmode_t'(cfg2_ff[4:3]);
         fs_en_ff   <= cfg2_ff[5];
      end else if (fail_event) begin
         cur_src_ff <= SRC_FRC;
      end else if (sw_ff == SW_SWAP && !sys_edge && !src_edge(new_src_ff)) begin
         cur_src_ff <= new_src_ff;
      end
   end

   // Oscillator control register bits
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         new_src_ff <= scs_src_t'(cfg2_ff[2:0]);
         lock_en_ff <= 1'b0;
         sec_en_ff  <= 1'b0;
      end else if (wr_osc) begin
         if (sw_ff == SW_IDLE && !sw_en_ff) begin
            new_src_ff <= scs_src_t'(reg_req_in.wdata[OSC_NEW_LSB +: 3]);
         end
         // Lock is set once and held until reset
         lock_en_ff <= lock_en_ff | reg_req_in.wdata[OSC_LOCK_BIT];
         sec_en_ff  <= reg_req_in.wdata[OSC_SECEN_BIT];
      end
   end

   // Switch request: software sets, hardware clears when done or refused
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         sw_en_ff <= 1'b0;
      end else if (wr_osc && reg_req_in.wdata[OSC_SWEN_BIT] && (!lock_en_ff || fs_en_ff)) begin
         sw_en_ff <= 1'b1;
      end else if (sw_done) begin
         sw_en_ff <= 1'b0;
      end
   end

   // Clock fail flag: a new failure wins over a clearing write
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         fail_ff <= 1'b0;
      end else if (fail_event) begin
         fail_ff <= 1'b1;
      end else if (wr_osc && !reg_req_in.wdata[OSC_FAIL_BIT]) begin
         fail_ff <= 1'b0;
      end
   end

   // Clock divider, loop feedback and tuning registers
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         doze_ff    <= CLK_DIV_RST[DIV_DOZE_LSB +: 3];
         doze_en_ff <= CLK_DIV_RST[DIV_DOZEN_BIT];
         frc_ps_ff  <= CLK_DIV_RST[DIV_FRCPS_LSB +: 3];
         post_ff    <= CLK_DIV_RST[DIV_POST_LSB +: 2];
         pre_ff     <= CLK_DIV_RST[DIV_PRE_LSB +: 5];
         fb_ff      <= LOOP_FB_RST;
         tune_ff    <= TUNE_RST;
      end else begin
         if (wr_div) begin
            doze_ff    <= reg_req_in.wdata[DIV_DOZE_LSB +: 3];
            doze_en_ff <= reg_req_in.wdata[DIV_DOZEN_BIT];
            frc_ps_ff  <= reg_req_in.wdata[DIV_FRCPS_LSB +: 3];
            post_ff    <= reg_req_in.wdata[DIV_POST_LSB +: 2];
            pre_ff     <= reg_req_in.wdata[DIV_PRE_LSB +: 5];
         end
         if (reg_req_in.wr && reg_req_in.addr == ADDR_LOOP_FB) begin
            fb_ff <= reg_req_in.wdata[8:0];
         end
         if (reg_req_in.wr && reg_req_in.addr == ADDR_TUNE) begin
            tune_ff <= reg_req_in.wdata[5:0];
         end
      end
   end

   // Halving and slowdown counters; instruction clock tops out at half the source
   assign doze_mask = 7'((8'h01 << doze_ff) - 8'h01);
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         sys_tick_ff <= 1'b0;
         periph_ff   <= 1'b0;
         instr_ff    <= 1'b0;
         doze_cnt_ff <= 7'h00;
      end else begin
         sys_tick_ff <= sys_edge;
         if (sys_edge) begin
            periph_ff   <= ~periph_ff;
            doze_cnt_ff <= doze_cnt_ff + 7'h01;
         end
         // Outside slowdown or at 1:1 the instruction clock copies the peripheral one, so no stale phase lasts
         if (!doze_en_ff || doze_ff == 3'h0) begin
            instr_ff <= periph_ff ^ sys_edge;
         end else if (sys_edge && (doze_cnt_ff & doze_mask) == doze_mask) begin
            instr_ff <= ~instr_ff;
         end
      end
   end

   // Oscillator and loop steering for current and pending sources
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         amp_en_ff   <= 1'b0;
         gain_ff     <= 1'b0;
         sec_out_ff  <= 1'b0;
         slow_en_ff  <= 1'b1;
         loop_en_ff  <= 1'b0;
         loop_pri_ff <= 1'b0;
      end else begin
         // External clock leaves the amplifier off
         amp_en_ff   <= (uses_pri(cur_src_ff) || uses_pri(new_src_ff)) &&
                        (pmode_ff == PM_XTAL || pmode_ff == PM_HS);
         gain_ff     <= (pmode_ff == PM_HS);
         sec_out_ff  <= sec_en_ff || cur_src_ff == SRC_SEC || new_src_ff == SRC_SEC;
         // Slow RC always runs as the watchdog and monitor reference
         slow_en_ff  <= 1'b1;
         loop_en_ff  <= is_loop(cur_src_ff) || is_loop(new_src_ff);
         loop_pri_ff <= is_loop(cur_src_ff) ? uses_pri(cur_src_ff) : uses_pri(new_src_ff);
      end
   end

   // Twelve-mode decode of the running configuration
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         mode_ff <= MD_FRC;
      end else begin
         unique case (cur_src_ff)
            SRC_FRC_DN:  mode_ff <= MD_FRC_DN;
            SRC_FRC_D16: mode_ff <= MD_FRC_D16;
            SRC_INTERNAL_SLOW_RC:    mode_ff <= MD_INTERNAL_SLOW_RC;
            SRC_SEC:     mode_ff <= MD_SEC;
            SRC_PRI_PLL: mode_ff <= (pmode_ff == PM_HS) ? MD_HS_PLL :
                                    (pmode_ff == PM_XTAL) ? MD_XT_PLL : MD_EC_PLL;
            SRC_PRI:     mode_ff <= (pmode_ff == PM_HS) ? MD_HS :
                                    (pmode_ff == PM_XTAL) ? MD_XT : MD_EC;
            SRC_FRC_PLL: mode_ff <= MD_FRC_PLL;
            SRC_FRC:     mode_ff <= MD_FRC;
         endcase
      end
   end

   // Read data stand only in the cycle after the strobe; unmapped reads give zero
   always_comb begin
      osc_word = 16'h0000;
      osc_word[OSC_CUR_LSB +: 3] = cur_src_ff;
      osc_word[OSC_NEW_LSB +: 3] = new_src_ff;
      osc_word[OSC_LOCK_BIT]     = lock_en_ff;
      osc_word[OSC_PLOCK_BIT]    = loop_lock;
      osc_word[OSC_FAIL_BIT]     = fail_ff;
      osc_word[OSC_SECEN_BIT]    = sec_en_ff;
      osc_word[OSC_SWEN_BIT]     = sw_en_ff;
   end
   always_ff @(posedge ref_clk_in) begin
      if (rst_in || !reg_req_in.rd) begin
         rdata_ff <= 16'h0000;
      end else begin
         unique case (reg_req_in.addr)
            ADDR_OSC_CTRL: rdata_ff <= osc_word;
            ADDR_CLK_DIV:  rdata_ff <= {1'b0, doze_ff, doze_en_ff, frc_ps_ff, post_ff, 1'b0, pre_ff};
            ADDR_LOOP_FB:  rdata_ff <= {7'h00, fb_ff};
            ADDR_TUNE:     rdata_ff <= {10'h000, tune_ff};
            default:       rdata_ff <= 16'h0000;
         endcase
      end
   end

   // Output drive
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         fail_out_ff <= 1'b0;
      end else begin
         fail_out_ff <= fail_ff;
      end
   end
   assign reg_rdata_out            = rdata_ff;
   assign primary_amp_enable_out   = amp_en_ff;
   assign primary_high_gain_out    = gain_ff;
   assign secondary_osc_enable_out = sec_out_ff;
   assign slow_rc_enable_out       = slow_en_ff;
   assign fast_rc_tune_out         = tune_ff;
   assign loop_enable_out          = loop_en_ff;
   assign loop_from_primary_out    = loop_pri_ff;
   assign loop_cfg_out             = '{pre: pre_ff, fb: fb_ff, post: post_ff};
   assign current_source_out       = cur_src_ff;
   assign clock_mode_out           = mode_ff;
   assign sys_clk_tick_out         = sys_tick_ff;
   assign instr_clk_out            = instr_ff;
   assign peripheral_clock_out     = periph_ff;
   assign clock_fail_out           = fail_out_ff;
endmodule
`default_nettype wire

// >>> hw/scs_pkg.sv
// Constants, types and register map of the system clock source selector
package scs_pkg;
   // Reference clock and nominal oscillator figures
   localparam int unsigned REF_CLK_HZ  = 10_000_000;
   localparam int unsigned FRC_NOM_HZ  = 7_370_000;
   localparam int unsigned INTERNAL_SLOW_RC_NOM_HZ = 32_768;
   localparam int unsigned SOSC_NOM_HZ = 32_768;
   localparam int unsigned XT_MIN_HZ   = 3_000_000;
   localparam int unsigned XT_MAX_HZ   = 10_000_000;
   localparam int unsigned HS_MAX_HZ   = 40_000_000;
   localparam int unsigned FCY_MAX_HZ  = 40_000_000;

   // Register indices on the plain register port
   localparam logic [3:0] ADDR_OSC_CTRL = 4'h0;
   localparam logic [3:0] ADDR_CLK_DIV  = 4'h1;
   localparam logic [3:0] ADDR_LOOP_FB  = 4'h2;
   localparam logic [3:0] ADDR_TUNE     = 4'h3;

   // Oscillator control register fields
   localparam int OSC_CUR_LSB   = 12;
   localparam int OSC_NEW_LSB   = 8;
   localparam int OSC_LOCK_BIT  = 7;
   localparam int OSC_PLOCK_BIT = 5;
   localparam int OSC_FAIL_BIT  = 3;
   localparam int OSC_SECEN_BIT = 1;
   localparam int OSC_SWEN_BIT  = 0;

   // Clock divider register fields
   localparam int DIV_DOZE_LSB  = 12;
   localparam int DIV_DOZEN_BIT = 11;
   localparam int DIV_FRCPS_LSB = 8;
   localparam int DIV_POST_LSB  = 6;
   localparam int DIV_PRE_LSB   = 0;

   // Reset values
   localparam logic [15:0] CLK_DIV_RST = 16'h0040;
   localparam logic [8:0]  LOOP_FB_RST = 9'h030;
   localparam logic [5:0]  TUNE_RST    = 6'h00;

   // Slow RC edges without a system edge before a failure is declared
   localparam logic [2:0] FAIL_LIMIT    = 3'h3;
   // New source edges seen before a switch may complete
   localparam logic [2:0] SWITCH_SETTLE = 3'h4;

   // Synchronised input lanes
   localparam int TK_FRC  = 0;
   localparam int TK_PRI  = 1;
   localparam int TK_SEC  = 2;
   localparam int TK_INTERNAL_SLOW_RC = 3;
   localparam int TK_PLL  = 4;
   localparam int TK_LOCK = 5;

   typedef enum logic [2:0] {
      SRC_FRC     = 3'b000, SRC_FRC_PLL = 3'b001,
      SRC_PRI     = 3'b010, SRC_PRI_PLL = 3'b011,
      SRC_SEC     = 3'b100, SRC_INTERNAL_SLOW_RC    = 3'b101,
      SRC_FRC_D16 = 3'b110, SRC_FRC_DN  = 3'b111
   } scs_src_t;

   typedef enum logic [1:0] {
      PM_EXT = 2'b00, PM_XTAL = 2'b01, PM_HS = 2'b10, PM_OFF = 2'b11
   } scs_pmode_t;

   // The twelve configured clock modes
   typedef enum logic [3:0] {
      MD_FRC_DN = 4'h0, MD_FRC_D16 = 4'h1, MD_INTERNAL_SLOW_RC = 4'h2, MD_SEC = 4'h3,
      MD_HS_PLL = 4'h4, MD_XT_PLL = 4'h5, MD_EC_PLL = 4'h6, MD_HS = 4'h7,
      MD_XT = 4'h8, MD_EC = 4'h9, MD_FRC_PLL = 4'ha, MD_FRC = 4'hb
   } scs_mode_t;

   typedef enum logic [1:0] {
      SW_IDLE = 2'b00, SW_WAIT_NEW = 2'b01, SW_SWAP = 2'b10
   } scs_sw_t;

   typedef struct packed {
      logic [3:0]  addr;
      logic [15:0] wdata;
      logic        wr;
      logic        rd;
   } scs_req_t;

   // Loop settings: prescale N1 = pre+2, feedback M = fb+2, postscale N2 from post
   typedef struct packed {
      logic [4:0] pre;
      logic [8:0] fb;
      logic [1:0] post;
   } scs_loop_t;
endpackage

// >>> test/scs_clock_select_sva.sv
// Port assertions for the clock source selector
`timescale 1ns/10ps
`default_nettype none
module scs_clock_select_sva
   import scs_pkg::*;
(
   // Watched ports
   input wire logic             ref_clk_in,
   input wire logic             rst_in,
   input wire scs_req_t         reg_req_in,
   input wire logic [1:0]       primary_mode_select_in,
   input wire logic             primary_amp_enable_out,
   input wire logic             primary_high_gain_out,
   input wire logic             slow_rc_enable_out,
   input wire logic             loop_enable_out,
   input wire logic [2:0]       current_source_out,
   input wire logic             sys_clk_tick_out,
   input wire logic             instr_clk_out,
   input wire logic             peripheral_clock_out,
   input wire logic             clock_fail_out
);
   default clocking @(posedge ref_clk_in); endclocking
   default disable iff (rst_in);
   logic slow_ff;
   // Slowdown mirrored from divider writes; a zero ratio keeps both clocks equal
   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         slow_ff <= 1'b0;
      end else if (reg_req_in.wr && reg_req_in.addr == ADDR_CLK_DIV) begin
         slow_ff <= reg_req_in.wdata[DIV_DOZEN_BIT] && (reg_req_in.wdata[DIV_DOZE_LSB +: 3] != 3'h0);
      end
   end
   a_slow_rc_on: assert property (slow_rc_enable_out)
      else $error("slow RC oscillator disabled");
   a_tick_toggles: assert property (sys_clk_tick_out |-> peripheral_clock_out != $past(peripheral_clock_out))
      else $error("peripheral clock missed a source edge");
   a_no_tick_hold: assert property (!sys_clk_tick_out |-> $stable(peripheral_clock_out))
      else $error("peripheral clock moved without a source edge");
   a_clocks_equal: assert property (!slow_ff [*3] |-> instr_clk_out == peripheral_clock_out)
      else $error("instruction and peripheral clocks differ");
   a_fail_to_fast: assert property ($rose(clock_fail_out) |-> current_source_out == SRC_FRC)
      else $error("failure did not fall back to fast RC");
   a_gain_mode: assert property ($stable(primary_mode_select_in) [*4] |->
      primary_high_gain_out == (primary_mode_select_in == PM_HS))
      else $error("high gain does not follow the mode");
   a_ext_no_amp: assert property ((primary_mode_select_in == PM_EXT && current_source_out[2:1] == 2'b01) [*3]
      |-> !primary_amp_enable_out)
      else $error("amplifier on in external clock mode");
   a_loop_used: assert property ((current_source_out == SRC_PRI_PLL || current_source_out == SRC_FRC_PLL) [*2]
      |-> loop_enable_out)
      else $error("loop source selected with loop off");
endmodule
bind scs_clock_select scs_clock_select_sva u_sva (.ref_clk_in, .rst_in, .reg_req_in, .primary_mode_select_in,
   .primary_amp_enable_out, .primary_high_gain_out, .slow_rc_enable_out, .loop_enable_out, .current_source_out,
   .sys_clk_tick_out, .instr_clk_out, .peripheral_clock_out, .clock_fail_out);
`default_nettype wire

// >>> test/scs_osc_model.sv
// Behavioural oscillators and loop that face the clock selector
`timescale 1ns/10ps
`default_nettype none
module scs_osc_model (
   // Control from the bench and the selector
   input  wire logic primary_stop_in,
   input  wire logic loop_enable_in,
   // Sensed clocks and lock
   output logic      fast_rc_clk_out,
   output logic      primary_clk_out,
   output logic      secondary_clk_out,
   output logic      slow_rc_clk_out,
   output logic      loop_clk_out,
   output logic      loop_locked_out
);
   // Scaled rates keep every source well below the sampling rate
   initial begin
      {fast_rc_clk_out, primary_clk_out, secondary_clk_out} = 3'h0;
      {slow_rc_clk_out, loop_clk_out, loop_locked_out} = 3'h0;
   end
   always #400 fast_rc_clk_out = ~fast_rc_clk_out;
   // A failed crystal stands low, which the monitor has to catch
   always #1000 primary_clk_out = primary_stop_in ? 1'b0 : ~primary_clk_out;
   always #4000 secondary_clk_out = ~secondary_clk_out;
   always #2500 slow_rc_clk_out = ~slow_rc_clk_out;
   // The loop only runs while enabled and reports lock after settling
   always #600 loop_clk_out = loop_enable_in ? ~loop_clk_out : 1'b0;
   always @(loop_enable_in) loop_locked_out <= #3000 loop_enable_in;
endmodule
`default_nettype wire

// >>> test/tb_scs_clock_select.sv
// Self-checking bench for the clock source selector
`timescale 1ns/10ps
`default_nettype none
module tb_scs_clock_select;
   import scs_pkg::*;
   logic ref_clk_in = 1'b0;
   logic rst_in = 1'b1;
   scs_req_t req = '0;
   logic [2:0] src_sel = 3'h0;
   logic [1:0] pm_sel = 2'h0;
   logic pri_stop = 1'b0;
   logic fs_en = 1'b1;
   logic frc_c, pri_c, sec_c, internal_slow_rc_c, loop_c, lock_c, loop_en, fail;
   logic amp, sec_out, lpri, instr, periph;
   logic [15:0] rdata;
   logic [2:0] cur;
   logic [3:0] mode;
   logic [5:0] tune;
   scs_loop_t loop_cfg;
   int miscompares = 0;
   int n_tests = 0;
   always #50 ref_clk_in = ~ref_clk_in;
   scs_osc_model u_osc (.primary_stop_in(pri_stop), .loop_enable_in(loop_en), .fast_rc_clk_out(frc_c),
      .primary_clk_out(pri_c), .secondary_clk_out(sec_c), .slow_rc_clk_out(internal_slow_rc_c), .loop_clk_out(loop_c),
      .loop_locked_out(lock_c));
   scs_clock_select dut (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .reg_req_in(req), .reg_rdata_out(rdata),
      .initial_source_select_in(src_sel), .primary_mode_select_in(pm_sel), .fail_safe_enable_in(fs_en),
      .fast_rc_clk_in(frc_c), .primary_osc_in_pin_in(pri_c), .secondary_osc_in_pin_in(sec_c),
      .slow_rc_clk_in(internal_slow_rc_c), .loop_clk_in(loop_c), .loop_locked_in(lock_c), .primary_amp_enable_out(amp),
      .primary_high_gain_out(), .secondary_osc_enable_out(sec_out), .slow_rc_enable_out(), .fast_rc_tune_out(tune),
      .loop_enable_out(loop_en), .loop_from_primary_out(lpri), .loop_cfg_out(loop_cfg), .current_source_out(cur),
      .clock_mode_out(mode), .sys_clk_tick_out(), .instr_clk_out(instr), .peripheral_clock_out(periph),
      .clock_fail_out(fail));
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_tests++;
      if (got !== exp) begin
         miscompares++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   // Straps change only inside reset so they pass the synchroniser before release
   task automatic do_reset(input logic [2:0] s, input logic [1:0] p);
      @(posedge ref_clk_in);
      src_sel <= s;
      pm_sel <= p;
      rst_in <= 1'b1;
      repeat (5) @(posedge ref_clk_in);
      rst_in <= 1'b0;
      repeat (4) @(posedge ref_clk_in);
      #1;
   endtask
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge ref_clk_in);
      req <= '{a, d, 1'b1, 1'b0};
      @(posedge ref_clk_in);
      req <= '0;
      repeat (2) @(posedge ref_clk_in);
      #1;
   endtask
   task automatic rd(input logic [3:0] a, input logic [15:0] exp);
      @(posedge ref_clk_in);
      req <= '{a, 16'h0000, 1'b0, 1'b1};
      @(posedge ref_clk_in);
      req <= '0;
      #1 chk(rdata, exp);
   endtask
   // Bounded wait for a source change; running out ends the run
   task automatic wait_src(input logic [2:0] s);
      for (int i = 0; i < 3000 && cur !== s; i++) @(posedge ref_clk_in);
      if (cur !== s) begin
         miscompares++;
         give_verdict();
      end
      repeat (3) @(posedge ref_clk_in);
      #1;
   endtask
   task automatic t_modes();
      logic [11:0] tbl [12] = '{12'h730, 12'h631, 12'h532, 12'h433, 12'h324, 12'h315,
                                12'h306, 12'h227, 12'h218, 12'h209, 12'h13a, 12'h03b};
      foreach (tbl[i]) begin
         do_reset(tbl[i][10:8], tbl[i][5:4]);
         chk(16'(mode), 16'(tbl[i][3:0]));
         chk(16'(cur), 16'(tbl[i][10:8]));
         chk(16'(lpri & loop_en), 16'(tbl[i][10:8] == 3'h3));
         chk(16'(sec_out), 16'(tbl[i][10:8] == 3'h4));
         chk(16'(amp), 16'(tbl[i][10:9] == 2'b01 && tbl[i][5:4] inside {2'b01, 2'b10}));
      end
      do_reset(3'h0, 2'h0);
      chk(16'(mode), 16'(MD_FRC));
      $display("modes done");
   endtask
   task automatic t_regs();
      rd(ADDR_CLK_DIV, CLK_DIV_RST);
      rd(ADDR_LOOP_FB, 16'(LOOP_FB_RST));
      rd(4'h9, 16'h0000);
      wr(ADDR_TUNE, 16'h002a);
      chk(16'(tune), 16'h002a);
      wr(ADDR_CLK_DIV, 16'h07df);
      chk(loop_cfg, 16'hf8c3);
      rd(ADDR_CLK_DIV, 16'h07df);
      wr(ADDR_CLK_DIV, 16'h00df);
      $display("registers done");
   endtask
   task automatic t_switch();
      wr(ADDR_OSC_CTRL, 16'h0001);
      repeat (8) @(posedge ref_clk_in);
      rd(ADDR_OSC_CTRL, 16'h0000);
      wr(ADDR_OSC_CTRL, 16'h0701);
      wait_src(SRC_FRC_DN);
      chk(16'(mode), 16'(MD_FRC_DN));
      wr(ADDR_OSC_CTRL, 16'h0201);
      wait_src(SRC_PRI);
      chk(16'(mode), 16'(MD_EC));
      rd(ADDR_OSC_CTRL, 16'h2200);
      $display("switching done");
   endtask
   task automatic t_fail();
      pri_stop <= 1'b1;
      wait_src(SRC_FRC);
      chk(16'(fail), 16'h0001);
      pri_stop <= 1'b0;
      $display("fail-safe done");
   endtask
   // Slowdown 1:2 must halve the instruction clock against the peripheral one
   task automatic t_doze();
      logic pc, ic;
      int np = 0;
      int ni = 0;
      wr(ADDR_CLK_DIV, 16'h1840);
      {pc, ic} = {periph, instr};
      for (int j = 0; j < 2000 && np < 8; j++) begin
         @(posedge ref_clk_in);
         #1;
         np += int'(periph !== pc);
         ni += int'(instr !== ic);
         {pc, ic} = {periph, instr};
      end
      chk(16'(np), 16'h0008);
      chk(16'(ni), 16'h0004);
      $display("slowdown done");
   endtask
   // With the monitor off a set lock refuses the switch request but keeps the new field
   task automatic t_lock();
      @(posedge ref_clk_in);
      fs_en <= 1'b0;
      do_reset(3'h0, 2'h0);
      wr(ADDR_OSC_CTRL, 16'h0080);
      wr(ADDR_OSC_CTRL, 16'h0781);
      rd(ADDR_OSC_CTRL, 16'h0780);
      $display("lock done");
   endtask
   initial begin
      do_reset(3'h0, 2'h0);
      t_modes();
      t_regs();
      t_switch();
      t_fail();
      t_doze();
      t_lock();
      give_verdict();
   end
endmodule
`default_nettype wire
